// ---- hw/analog_pin_select_pkg.sv ----
/*
 Package for the analog pin select registers: special function register
 addresses, field positions, reset values and the carrier structs.
 Assumes an 8-bit special function register bus on a single clock.
*/
package analog_pin_select_pkg;

	localparam logic [7:0] PORT0_ANALOG_CONNECT_ADDR = 8'h9a;
	localparam logic [7:0] SENSE_CHANNEL_SELECT_ADDR = 8'hab;

	localparam int         SENSE_DISCONNECT_BIT      = 7;
	localparam int         SENSE_RESERVED_BIT        = 6;
	localparam int         SENSE_CODE_MSB            = 5;
	localparam int         SENSE_CHANNELS            = 43;
	localparam logic [5:0] SENSE_CODE_LAST           = 6'h2a;

	localparam logic [7:0] SENSE_CHANNEL_SELECT_RST  = 8'h80;
	localparam logic [7:0] PORT0_ANALOG_CONNECT_RST  = 8'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef struct packed {
		logic                      disconnect;
		logic                      code_valid;
		logic [SENSE_CHANNELS-1:0] channel_en;
	} sense_sel_s;

endpackage

// ---- hw/analog_pin_select_regs.sv ----
/*
 Sense channel select register and port-0 analog connect register, with
 the decoders that turn them into analog switch enables.
 Assumes the processor's special function register bus on the same clock;
 reads return data combinationally in the cycle of the read strobe.
 The switch enables come from flip-flops; the analog switches sit outside
 and must tolerate any pin combination that software chooses.
*/
// Functional notes
// - Disconnect bit 7 set isolates the sense converter from all pins; here it clears only the sense channel enables, not the port-0 connects.
// - Disconnect bit: 0 connected, 1 disconnected; resets to 1.
// - Code in bits 5:0 selects one channel, 0 to 42; higher reserved.
// - For conversion the multiplexer presents the selected pin.
// - Several pin connect bits may be set together for sensing.
// - Each port-0 bit connects its pin when 1; all reset to 0.
// - Port-1 connect register, same layout, lies outside this block.
module analog_pin_select_regs
	import analog_pin_select_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_ce,
	input  wire sfr_req_s                  i_sfr,
	output logic      [7:0]                o_sfr_rdata,
	output logic                           o_sfr_hit,
	output logic      [7:0]                o_port0_pin_connect,
	output logic      [SENSE_CHANNELS-1:0] o_sense_channel_en,
	output logic                           o_sense_disconnect,
	output logic      [5:0]                o_sense_channel_code
);

	logic [7:0]                port0_analog_connect;
	logic [7:0]                next_port0_analog_connect;
	logic                      port0_wr_en;

	logic                      sense_disconnect;
	logic                      next_sense_disconnect;
	logic                      sense_reserved;
	logic                      next_sense_reserved;
	logic [5:0]                sense_channel_code;
	logic [5:0]                next_sense_channel_code;
	logic [7:0]                sense_channel_select;
	logic                      sense_wr_en;

	logic [SENSE_CHANNELS-1:0] next_channel_match;
	sense_sel_s                sense_sel;
	sense_sel_s                next_sense_sel;

	// Address decode, shared by the write enables and the read hit flag
	function automatic logic is_port0_addr(input logic [7:0] a);
		is_port0_addr = (a == PORT0_ANALOG_CONNECT_ADDR);
	endfunction

	function automatic logic is_sense_addr(input logic [7:0] a);
		is_sense_addr = (a == SENSE_CHANNEL_SELECT_ADDR);
	endfunction

	// Port-1 connect address is left undecoded; it lives elsewhere
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = is_port0_addr(a) || is_sense_addr(a);
	endfunction

	// Codes past the last channel are reserved and select nothing
	function automatic logic code_ok(input logic [5:0] code);
		code_ok = (code <= SENSE_CODE_LAST);
	endfunction

	function automatic logic code_match(input logic [5:0] code,
	                                    input int         c);
		code_match = code_ok(code) && (code == 6'(c));
	endfunction

	always_comb begin
		port0_wr_en = i_ce && i_sfr.wr && is_port0_addr(i_sfr.addr);
	end

	always_comb begin
		sense_wr_en = i_ce && i_sfr.wr && is_sense_addr(i_sfr.addr);
	end

	// Any mix of pins is accepted; one pin for conversion is up to software
	always_comb begin
		next_port0_analog_connect = port0_analog_connect;
		if (port0_wr_en) begin
			next_port0_analog_connect = i_sfr.wdata;
		end
	end

	always_comb begin
		next_sense_disconnect = sense_disconnect;
		if (sense_wr_en) begin
			next_sense_disconnect = i_sfr.wdata[SENSE_DISCONNECT_BIT];
		end
	end

	// Stored as written so a read shows exactly what software put there
	always_comb begin
		next_sense_reserved = sense_reserved;
		if (sense_wr_en) begin
			next_sense_reserved = i_sfr.wdata[SENSE_RESERVED_BIT];
		end
	end

	always_comb begin
		next_sense_channel_code = sense_channel_code;
		if (sense_wr_en) begin
			next_sense_channel_code = i_sfr.wdata[SENSE_CODE_MSB:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			port0_analog_connect <= PORT0_ANALOG_CONNECT_RST;
		end else if (i_ce) begin
			port0_analog_connect <= next_port0_analog_connect;
		end
	end

	// Sensing starts isolated from every pin
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sense_disconnect <=
				SENSE_CHANNEL_SELECT_RST[SENSE_DISCONNECT_BIT];
		end else if (i_ce) begin
			sense_disconnect <= next_sense_disconnect;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sense_reserved <=
				SENSE_CHANNEL_SELECT_RST[SENSE_RESERVED_BIT];
		end else if (i_ce) begin
			sense_reserved <= next_sense_reserved;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sense_channel_code <=
				SENSE_CHANNEL_SELECT_RST[SENSE_CODE_MSB:0];
		end else if (i_ce) begin
			sense_channel_code <= next_sense_channel_code;
		end
	end

	always_comb begin
		sense_channel_select =
			{sense_disconnect, sense_reserved, sense_channel_code};
	end

	generate
		for (genvar c = 0; c < SENSE_CHANNELS; c++) begin : g_ch
			assign next_channel_match[c] =
				code_match(next_sense_channel_code, c);
		end
	endgenerate

	always_comb begin
		next_sense_sel            = '0;
		next_sense_sel.disconnect = next_sense_disconnect;
		next_sense_sel.code_valid = code_ok(next_sense_channel_code);
		// Disconnect overrides whatever code is programmed
		if (!next_sense_disconnect) begin
			next_sense_sel.channel_en = next_channel_match;
		end
	end

	// Decoding into flops keeps decoder glitches off the analog switches
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sense_sel.disconnect <=
				SENSE_CHANNEL_SELECT_RST[SENSE_DISCONNECT_BIT];
			sense_sel.code_valid <=
				(SENSE_CHANNEL_SELECT_RST[SENSE_CODE_MSB:0] <= SENSE_CODE_LAST);
			sense_sel.channel_en <= '0;
		end else if (i_ce) begin
			sense_sel <= next_sense_sel;
		end
	end

	generate
		for (genvar p = 0; p < 8; p++) begin : g_pin
			assign o_port0_pin_connect[p] = port0_analog_connect[p];
		end
	endgenerate

	assign o_sense_channel_en   =
		sense_sel.channel_en & {SENSE_CHANNELS{sense_sel.code_valid}};
	assign o_sense_disconnect   = sense_sel.disconnect;
	assign o_sense_channel_code = sense_channel_code;

	always_comb begin
		o_sfr_hit = i_sfr.rd && addr_hit(i_sfr.addr);
	end

	// Unmapped reads and idle cycles return zero
	always_comb begin
		o_sfr_rdata = 8'h00;
		if (i_sfr.rd) begin
			case (i_sfr.addr)
				PORT0_ANALOG_CONNECT_ADDR: o_sfr_rdata = port0_analog_connect;
				SENSE_CHANNEL_SELECT_ADDR: o_sfr_rdata = sense_channel_select;
				default:                   o_sfr_rdata = 8'h00;
			endcase
		end
	end

endmodule // analog_pin_select_regs

// ---- testbench/aps_properties.sv ----
/*
 Port checker for analog_pin_select_regs: concurrent assertions on the
 design's ports only. Assumes one clock and a synchronous active-low reset.
*/
module aps_properties
	import analog_pin_select_pkg::*;
(
	input wire logic                      i_clk,
	input wire logic                      i_rst_n,
	input wire logic                      i_ce,
	input wire sfr_req_s                  i_sfr,
	input wire logic [7:0]                o_sfr_rdata,
	input wire logic                      o_sfr_hit,
	input wire logic [7:0]                o_port0_pin_connect,
	input wire logic [SENSE_CHANNELS-1:0] o_sense_channel_en,
	input wire logic                      o_sense_disconnect,
	input wire logic [5:0]                o_sense_channel_code
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence p0_wr;
		i_ce && i_sfr.wr && i_sfr.addr == PORT0_ANALOG_CONNECT_ADDR;
	endsequence

	sequence sense_wr;
		i_ce && i_sfr.wr && i_sfr.addr == SENSE_CHANNEL_SELECT_ADDR;
	endsequence

	a_disc_isolates: assert property (o_sense_disconnect |->
		!o_sense_channel_en) else $error("switch on while isolated");
	a_reset_vals: assert property ($rose(i_rst_n) |->
		o_sense_disconnect && o_port0_pin_connect == 8'h00 &&
		!o_sense_channel_en) else $error("reset values");
	a_code_onehot: assert property (
		$onehot0(o_sense_channel_en)) else $error("two channels");
	a_code_decode: assert property (!o_sense_disconnect &&
		o_sense_channel_code <= SENSE_CODE_LAST |-> o_sense_channel_en ==
		43'h1 << o_sense_channel_code) else $error("decode");
	a_rsvd_none: assert property (o_sense_channel_code > SENSE_CODE_LAST |->
		!o_sense_channel_en) else $error("reserved code");
	a_p0_write: assert property (p0_wr |=>
		o_port0_pin_connect == $past(i_sfr.wdata)) else $error("write");
	a_sense_write: assert property (sense_wr |=>
		o_sense_disconnect == $past(i_sfr.wdata[SENSE_DISCONNECT_BIT]) &&
		o_sense_channel_code == $past(i_sfr.wdata[SENSE_CODE_MSB:0]))
		else $error("sense write");
	a_ce_hold: assert property (!i_ce |=>
		$stable(o_port0_pin_connect) && $stable(o_sense_channel_code))
		else $error("write while held");
	a_read_back: assert property (i_sfr.rd &&
		i_sfr.addr == PORT0_ANALOG_CONNECT_ADDR |->
		o_sfr_hit && o_sfr_rdata == o_port0_pin_connect) else $error("read");
	a_sense_read: assert property (i_sfr.rd &&
		i_sfr.addr == SENSE_CHANNEL_SELECT_ADDR |-> o_sfr_hit &&
		o_sfr_rdata[SENSE_DISCONNECT_BIT] == o_sense_disconnect &&
		o_sfr_rdata[SENSE_CODE_MSB:0] == o_sense_channel_code)
		else $error("sense read");
	a_unmapped_read: assert property (i_sfr.rd &&
		i_sfr.addr != PORT0_ANALOG_CONNECT_ADDR &&
		i_sfr.addr != SENSE_CHANNEL_SELECT_ADDR |->
		!o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read");
	a_idle_quiet: assert property (!i_sfr.rd |->
		!o_sfr_hit && o_sfr_rdata == 8'h00) else $error("data without read");
endmodule // aps_properties
bind analog_pin_select_regs aps_properties chk (.i_clk, .i_rst_n, .i_ce,
	.i_sfr, .o_sfr_rdata, .o_sfr_hit, .o_port0_pin_connect,
	.o_sense_channel_en, .o_sense_disconnect, .o_sense_channel_code);

// ---- testbench/testbench.sv ----
/*
 Bench for the analog pin select registers.
 Drives the register bus itself; the port checker is bound separately.
*/
module testbench
	import analog_pin_select_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                      i_clk   = 1'b0;
	logic                      i_rst_n = 1'b0;
	logic                      i_ce    = 1'b1;
	sfr_req_s                  i_sfr   = '0;
	logic                      hit;
	logic                      disc;
	logic [7:0]                rdata;
	logic [7:0]                p0;
	logic [5:0]                code;
	logic [SENSE_CHANNELS-1:0] en;
	int                        bad_count = 0;
	int                        checks    = 0;

	analog_pin_select_regs dut (
		.i_clk                (i_clk),
		.i_rst_n              (i_rst_n),
		.i_ce                 (i_ce),
		.i_sfr                (i_sfr),
		.o_sfr_rdata          (rdata),
		.o_sfr_hit            (hit),
		.o_port0_pin_connect  (p0),
		.o_sense_channel_en   (en),
		.o_sense_disconnect   (disc),
		.o_sense_channel_code (code)
	);

	initial begin
		forever #4 i_clk = ~i_clk;
	end

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	task automatic cmp_read(input logic exp_hit, input logic [7:0] exp_data);
		checks++;
		if ({hit, rdata} !== {exp_hit, exp_data}) begin
			bad_count++;
			$display("unexpected at %0t: read %b %h", $time, hit, rdata);
		end
	endtask

	// One bus cycle and one idle cycle, so a strobe never changes twice
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		i_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		#1 i_sfr = '0;
		@(posedge i_clk);
		#1;
	endtask

	// Read data is combinational, so it is taken at the sampling edge
	task automatic sfr_read(input logic [7:0] a, input logic e_hit,
	                        input logic [7:0] e_data);
		i_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		cmp_read(e_hit, e_data);
		#1 i_sfr = '0;
		@(posedge i_clk);
		#1;
	endtask

	task automatic check_reset;
		sfr_read(SENSE_CHANNEL_SELECT_ADDR, 1'b1, 8'h80);
		sfr_read(PORT0_ANALOG_CONNECT_ADDR, 1'b1, 8'h00);
		cmp({disc, en}, {1'b1, 43'h0});
	endtask

	task automatic sweep_codes;
		for (int c = 0; c < 64; c++) begin
			sfr_write(SENSE_CHANNEL_SELECT_ADDR, 8'(c));
			cmp(en, (c < 43) ? (64'h1 << c) : 64'h0);
			cmp(code, 64'(c));
		end
	endtask

	task automatic check_disconnect;
		sfr_write(SENSE_CHANNEL_SELECT_ADDR, 8'h85);
		cmp({disc, en}, {1'b1, 43'h0});
		sfr_read(SENSE_CHANNEL_SELECT_ADDR, 1'b1, 8'h85);
		sfr_write(SENSE_CHANNEL_SELECT_ADDR, 8'h05);
		cmp({disc, en}, {1'b0, 43'h20});
	endtask

	task automatic check_pins;
		sfr_write(PORT0_ANALOG_CONNECT_ADDR, 8'ha5);
		sfr_read(PORT0_ANALOG_CONNECT_ADDR, 1'b1, 8'ha5);
		cmp(p0, 8'ha5);
		sfr_write(PORT0_ANALOG_CONNECT_ADDR, 8'h04);
		cmp(p0, 8'h04);
		sfr_write(PORT0_ANALOG_CONNECT_ADDR, 8'h00);
		cmp(p0, 8'h00);
	endtask

	task automatic check_hold_and_unmapped;
		sfr_write(PORT0_ANALOG_CONNECT_ADDR, 8'h3c);
		i_ce = 1'b0;
		sfr_write(PORT0_ANALOG_CONNECT_ADDR, 8'h0f);
		i_ce = 1'b1;
		cmp(p0, 8'h3c);
		sfr_read(8'h55, 1'b0, 8'h00);
		sfr_read(8'h9b, 1'b0, 8'h00);
		sfr_write(8'h9b, 8'hff);
		cmp(p0, 8'h3c);
	endtask

	task automatic check_mid_reset;
		sfr_write(SENSE_CHANNEL_SELECT_ADDR, 8'h05);
		i_rst_n = 1'b0;
		@(posedge i_clk);
		#1 i_rst_n = 1'b1;
		cmp({disc, code, en}, {1'b1, 6'h00, 43'h0});
		cmp(p0, 8'h00);
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		check_reset();
		sweep_codes();
		check_disconnect();
		check_pins();
		check_hold_and_unmapped();
		check_mid_reset();
		report_and_stop();
	end
endmodule // testbench
